// ===== hw/mor_hdr_if.sv
// Carries a decoded header from the control logic to the header checker and back.
`timescale 1ns/1ps
interface mor_hdr_if;
	logic [29:0] phr;
	logic        good;
	logic [10:0] len;
	modport ctl (output phr, input good, input len);
	modport chk (input phr, output good, output len);
endinterface

// ===== hw/mor_phr_check.sv
// Header checker: HCS CRC-8 over the header bits and nonzero length test.
`timescale 1ns/1ps
module mor_phr_check
(
	mor_hdr_if.chk hdr
);
	import mor_pkg::*;

	function automatic logic [7:0] mor_crc8(input logic [21:0] data);
		logic [7:0] crc;
		logic       fb;
		crc = MOR_HCS_INIT;
		for (int i = 21; i >= 0; i--)
		begin
			fb  = crc[7] ^ data[i];
			crc = {crc[6:0], 1'b0} ^ (fb ? MOR_HCS_POLY : 8'h00);
		end
		return crc;
	endfunction

	wire [7:0] calc_crc = mor_crc8(hdr.phr[MOR_PHR_DATA-1:0]);
	wire       crc_ok   = (calc_crc == hdr.phr[MOR_PHR_HCS +: 8]);

	assign hdr.len  = hdr.phr[MOR_PHR_LEN +: 11];
	// A frame starts only with a valid CRC and a length above zero.
	assign hdr.good = crc_ok && (hdr.len != 11'h000);
endmodule

// ===== hw/mor_pkg.sv
// Shared constants and types for the MR-OFDM receiver control block.
package mor_pkg;
	// Register byte offsets on the Wishbone bus.
	localparam logic [4:0] MOR_OFS_CTRL    = 5'h00;
	localparam logic [4:0] MOR_OFS_TXHDR   = 5'h04;
	localparam logic [4:0] MOR_OFS_RXHDR   = 5'h08;
	localparam logic [4:0] MOR_OFS_SEED    = 5'h0c;
	localparam logic [4:0] MOR_OFS_LEN_HI  = 5'h10;
	localparam logic [4:0] MOR_OFS_LEN_LO  = 5'h14;
	localparam logic [4:0] MOR_OFS_ENERGY  = 5'h18;
	localparam logic [4:0] MOR_OFS_EVENT   = 5'h1c;
	// Control register fields and reset value.
	localparam int MOR_CTRL_EN   = 0;
	localparam int MOR_CTRL_LFO  = 1;
	localparam int MOR_CTRL_RXO  = 2;
	localparam int MOR_CTRL_POI  = 3;
	localparam int MOR_CTRL_OPT  = 4;
	localparam int MOR_CTRL_PDT  = 6;
	localparam logic [8:0] MOR_CTRL_RST = 9'h004;
	// Transmit header register fields and reset value.
	localparam int MOR_TXH_RSV   = 4;
	localparam int MOR_TXH_RO    = 3;
	localparam logic [7:0] MOR_TXH_RST = 8'h00;
	localparam logic [7:0] MOR_TXH_WMASK = 8'hf7;
	// Receive header status: spurious compensation enable position.
	localparam int MOR_RXH_SPC   = 3;
	// Event register bit positions.
	localparam int MOR_EV_HOLD   = 0;
	localparam int MOR_EV_FS     = 1;
	localparam int MOR_EV_RESYNC = 2;
	localparam int MOR_EV_FREEZE = 8;
	// Received header bit positions.
	localparam int MOR_PHR_W     = 30;
	localparam int MOR_PHR_RATE  = 0;
	localparam int MOR_PHR_RB5   = 5;
	localparam int MOR_PHR_LEN   = 6;
	localparam int MOR_PHR_TX_RESERVED_HDR_BIT_B  = 17;
	localparam int MOR_PHR_TX_RESERVED_HDR_BIT_C  = 18;
	localparam int MOR_PHR_SEED  = 19;
	localparam int MOR_PHR_TX_RESERVED_HDR_BIT_D  = 21;
	localparam int MOR_PHR_HCS   = 22;
	localparam int MOR_PHR_DATA  = 22;
	localparam logic [7:0] MOR_HCS_POLY = 8'h07;
	localparam logic [7:0] MOR_HCS_INIT = 8'hff;
	// Power rise per symbol above which the preamble search restarts, in dB.
	localparam logic [7:0] MOR_RESYNC_RISE_DB = 8'h0c;
	// Header rate per bandwidth option 1 to 4.
	localparam logic [2:0] MOR_HDR_RATE_OPT1 = 3'h0;
	localparam logic [2:0] MOR_HDR_RATE_OPT2 = 3'h0;
	localparam logic [2:0] MOR_HDR_RATE_OPT3 = 3'h1;
	localparam logic [2:0] MOR_HDR_RATE_OPT4 = 3'h2;
	// Descrambler seeds for seed index 0 to 3.
	localparam logic [8:0] MOR_SEED0 = 9'h017;
	localparam logic [8:0] MOR_SEED1 = 9'h177;
	localparam logic [8:0] MOR_SEED2 = 9'h01c;
	localparam logic [8:0] MOR_SEED3 = 9'h17c;

	typedef enum logic [2:0] {ST_OFF, ST_HUNT, ST_SYNC, ST_HDR, ST_RECV} mor_state_t;
endpackage

// ===== hw/mor_rx_ctrl.sv
// MR-OFDM receive control: preamble hunt, header check, status latching, registers.
`timescale 1ns/1ps
module mor_rx_ctrl
	import mor_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [4:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Receive datapath events
	input  wire logic        stf_detect,
	input  wire logic        sync_done,
	input  wire logic        phr_valid,
	input  wire logic [29:0] phr_bits,
	input  wire logic        frame_end,
	input  wire logic        sym_pwr_valid,
	input  wire logic [7:0]  sym_pwr_db,
	input  wire logic [7:0]  avg_power,
	// Receive datapath control
	output logic             hunt_enable,
	output logic             reduced_span,
	output logic             gain_freeze,
	output logic             gain_hold_pulse,
	output logic             frame_start_pulse,
	output logic             resync_pulse,
	output logic [2:0]       hdr_rate_code,
	output logic [8:0]       descr_seed,
	output logic [1:0]       bandwidth_option,
	output logic             interleaving_depth_select,
	output logic [2:0]       preamble_detect_threshold,
	output logic             spurious_comp_enable,
	// Transmit header composition
	output logic [2:0]       tx_rate_code,
	output logic [3:0]       tx_reserved_bits
);
	import mor_pkg::*;

	function automatic logic [8:0] mor_seed_of(input logic [1:0] idx);
		case (idx)
			2'h0:    return MOR_SEED0;
			2'h1:    return MOR_SEED1;
			2'h2:    return MOR_SEED2;
			default: return MOR_SEED3;
		endcase
	endfunction

	function automatic logic [2:0] mor_hdr_rate_of(input logic [1:0] opt);
		case (opt)
			2'h0:    return MOR_HDR_RATE_OPT1;
			2'h1:    return MOR_HDR_RATE_OPT2;
			2'h2:    return MOR_HDR_RATE_OPT3;
			default: return MOR_HDR_RATE_OPT4;
		endcase
	endfunction

	mor_state_t  state_q, state_d;
	logic [8:0]  ctrl_q;
	logic [7:0]  txh_q;
	logic [7:0]  rxh_q;
	logic [1:0]  seed_idx_q;
	logic [10:0] len_q;
	logic [7:0]  energy_q;
	logic [2:0]  ev_q;
	logic        freeze_q;
	logic [7:0]  pwr_prev_q;
	logic        pwr_seen_q;
	logic        ack_q;
	logic [31:0] rdat_q;
	logic        hold_p_q, fs_p_q, rs_p_q, hunt_q;
	logic [2:0]  hdr_rate_q;
	logic [8:0]  seed_q;

	mor_hdr_if hdr ();
	assign hdr.phr = phr_bits;

	mor_phr_check u_check
	(
		.hdr (hdr.chk)
	);

	// Bus decode.
	wire       bus_req  = wb_cyc_i && wb_stb_i && !ack_q;
	wire       wr       = bus_req && wb_we_i && wb_sel_i[0];
	wire       wr_hi    = bus_req && wb_we_i && wb_sel_i[1];
	wire       sel_ctrl = (wb_adr_i == MOR_OFS_CTRL);
	wire       sel_txh  = (wb_adr_i == MOR_OFS_TXHDR);
	wire       sel_rxh  = (wb_adr_i == MOR_OFS_RXHDR);
	wire       sel_ev   = (wb_adr_i == MOR_OFS_EVENT);
	wire [2:0] ev_clr   = (wr && sel_ev) ? wb_dat_i[2:0] : 3'h0;
	// A software write in the frame start cycle must not be lost to the capture.
	wire       spc_next = (wr && sel_rxh) ? wb_dat_i[MOR_RXH_SPC] : rxh_q[MOR_RXH_SPC];

	// Control fields.
	wire       en     = ctrl_q[MOR_CTRL_EN];
	wire       rxo_en = ctrl_q[MOR_CTRL_RXO];
	wire [1:0] opt    = ctrl_q[MOR_CTRL_OPT +: 2];

	// Datapath conditions.
	wire       pwr_jump = sym_pwr_valid && pwr_seen_q
		&& ({1'b0, sym_pwr_db} > ({1'b0, pwr_prev_q} + {1'b0, MOR_RESYNC_RISE_DB}));
	wire       in_frame = (state_q == ST_SYNC) || (state_q == ST_HDR) || (state_q == ST_RECV);
	wire       resync   = en && rxo_en && in_frame && pwr_jump;
	wire       det_hit  = en && (state_q == ST_HUNT) && stf_detect;
	wire       fs_hit   = en && !resync && (state_q == ST_HDR) && phr_valid && hdr.good;

	// Read multiplexer.
	wire [31:0] rd_mux =
		sel_ctrl ? {23'h0, ctrl_q} :
		sel_txh  ? {24'h0, txh_q} :
		sel_rxh  ? {24'h0, rxh_q} :
		(wb_adr_i == MOR_OFS_SEED)   ? {30'h0, seed_idx_q} :
		(wb_adr_i == MOR_OFS_LEN_HI) ? {29'h0, len_q[10:8]} :
		(wb_adr_i == MOR_OFS_LEN_LO) ? {24'h0, len_q[7:0]} :
		(wb_adr_i == MOR_OFS_ENERGY) ? {24'h0, energy_q} :
		sel_ev   ? {23'h0, freeze_q, 5'h0, ev_q} :
		32'h0;

	// Receive sequencing.
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_OFF:  state_d = ST_HUNT;
			ST_HUNT: if (stf_detect) state_d = ST_SYNC;
			ST_SYNC: if (sync_done) state_d = ST_HDR;
			ST_HDR:  if (phr_valid) state_d = hdr.good ? ST_RECV : ST_HUNT;
			ST_RECV: if (frame_end) state_d = ST_HUNT;
			default: state_d = ST_OFF;
		endcase
		if (resync)
			state_d = ST_HUNT;
		if (!en)
			state_d = ST_OFF;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			state_q <= ST_OFF;
		else
			state_q <= state_d;
	end

	// Gain freeze holds from detection until the search restarts or the block is disabled.
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			freeze_q <= 1'b0;
		else if (det_hit)
			freeze_q <= 1'b1;
		else if (state_d == ST_HUNT || state_d == ST_OFF)
			freeze_q <= 1'b0;
	end

	// Power tracking; first symbol after a restart has no reference.
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n || !in_frame || resync)
		begin
			pwr_prev_q <= 8'h00;
			pwr_seen_q <= 1'b0;
		end
		else if (sym_pwr_valid)
		begin
			pwr_prev_q <= sym_pwr_db;
			pwr_seen_q <= 1'b1;
		end
	end

	// Event pulses and sticky flags; a new event wins over a clear.
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			hold_p_q <= 1'b0;
			fs_p_q   <= 1'b0;
			rs_p_q   <= 1'b0;
			ev_q     <= 3'h0;
		end
		else
		begin
			hold_p_q <= det_hit;
			fs_p_q   <= fs_hit;
			rs_p_q   <= resync;
			ev_q     <= (ev_q & ~ev_clr) | {resync, fs_hit, det_hit};
		end
	end

	// Header status captured only at frame start.
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			seed_idx_q <= 2'h0;
			len_q      <= 11'h000;
			energy_q   <= 8'h00;
		end
		else if (fs_hit)
		begin
			seed_idx_q <= phr_bits[MOR_PHR_SEED +: 2];
			len_q      <= hdr.len;
			energy_q   <= avg_power;
		end
	end

	// Receive header status; the compensation enable is software owned.
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			rxh_q <= 8'h00;
		else if (fs_hit)
			rxh_q <= {phr_bits[MOR_PHR_TX_RESERVED_HDR_BIT_D], phr_bits[MOR_PHR_TX_RESERVED_HDR_BIT_C],
				phr_bits[MOR_PHR_TX_RESERVED_HDR_BIT_B], phr_bits[MOR_PHR_RB5],
				spc_next, phr_bits[MOR_PHR_RATE +: 3]};
		else if (wr && sel_rxh)
			rxh_q[MOR_RXH_SPC] <= wb_dat_i[MOR_RXH_SPC];
	end

	// Software registers.
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			ctrl_q <= MOR_CTRL_RST;
			txh_q  <= MOR_TXH_RST;
		end
		else
		begin
			if (wr && sel_ctrl)
				ctrl_q[7:0] <= wb_dat_i[7:0];
			if (wr_hi && sel_ctrl)
				ctrl_q[8] <= wb_dat_i[8];
			if (wr && sel_txh)
				txh_q <= wb_dat_i[7:0] & MOR_TXH_WMASK;
		end
	end

	// Bus answer one cycle after the request is seen.
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			ack_q  <= 1'b0;
			rdat_q <= 32'h0;
		end
		else
		begin
			ack_q  <= bus_req;
			rdat_q <= bus_req ? rd_mux : 32'h0;
		end
	end

	// Registered decode toward the datapath.
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			hdr_rate_q <= MOR_HDR_RATE_OPT1;
			seed_q     <= MOR_SEED0;
			hunt_q     <= 1'b0;
		end
		else
		begin
			hunt_q     <= (state_d == ST_HUNT);
			hdr_rate_q <= mor_hdr_rate_of(opt);
			seed_q     <= mor_seed_of(seed_idx_q);
		end
	end

	assign wb_ack_o                  = ack_q;
	assign wb_dat_o                  = rdat_q;
	assign hunt_enable               = hunt_q;
	assign reduced_span              = ctrl_q[MOR_CTRL_LFO];
	assign gain_freeze               = freeze_q;
	assign gain_hold_pulse           = hold_p_q;
	assign frame_start_pulse         = fs_p_q;
	assign resync_pulse              = rs_p_q;
	assign hdr_rate_code             = hdr_rate_q;
	assign descr_seed                = seed_q;
	assign bandwidth_option          = opt;
	assign interleaving_depth_select = ctrl_q[MOR_CTRL_POI];
	assign preamble_detect_threshold = ctrl_q[MOR_CTRL_PDT +: 3];
	assign spurious_comp_enable      = rxh_q[MOR_RXH_SPC];
	// Reserved bits go only to the transmit header and to the bus read-back; no other logic reads them.
	assign tx_reserved_bits          = txh_q[MOR_TXH_RSV +: 4];
	assign tx_rate_code              = txh_q[2:0];

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	freeze_on_det_a: assert property (det_hit |=> gain_freeze && gain_hold_pulse)
		else $error("gain not frozen after preamble detect");
	hold_once_a: assert property (gain_hold_pulse |=> !gain_hold_pulse)
		else $error("gain hold pulse longer than one cycle");
	fs_cause_a: assert property (frame_start_pulse |-> $past(state_q == ST_HDR && phr_valid)
		&& len_q != 11'h000)
		else $error("frame start without valid nonzero header");
	rate_latch_a: assert property (fs_hit |=> rxh_q[2:0] == $past(phr_bits[2:0])
		&& seed_idx_q == $past(phr_bits[MOR_PHR_SEED +: 2]))
		else $error("header status not latched at frame start");
	len_latch_a: assert property (fs_hit |=> len_q == $past(phr_bits[MOR_PHR_LEN +: 11]))
		else $error("frame length not latched");
	energy_cap_a: assert property (fs_hit |=> energy_q == $past(avg_power))
		else $error("energy value not captured");
	resync_hunt_a: assert property (resync |=> state_q == ST_HUNT && resync_pulse)
		else $error("no restart after power jump");
	no_resync_a: assert property ((!rxo_en || !sym_pwr_valid) |=> !resync_pulse)
		else $error("restart while override disabled");
	txh_ro_a: assert property (txh_q[MOR_TXH_RO] == 1'b0)
		else $error("read-only transmit header bit set");
	seed_map_a: assert property (seed_idx_q == 2'h3 ##1 seed_idx_q == 2'h3
		|-> descr_seed == MOR_SEED3)
		else $error("descrambler seed mismatch");
	hdr_rate_a: assert property ($stable(opt) [*2] |-> hdr_rate_code == mor_hdr_rate_of(opt))
		else $error("header rate does not follow option");
	ack_one_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

	frame_ok_c: cover property (det_hit ##[1:300] fs_hit);
	resync_c: cover property (resync);
	bad_hdr_c: cover property (state_q == ST_HDR && phr_valid && !hdr.good);
endmodule

// ===== test/mor_tx_model.sv
// Behavioural remote transmitter that drives the receive datapath events.
`timescale 1ns/1ps
module mor_tx_model
(
	// Clock
	input  wire logic        sys_clk,
	// Datapath events
	output logic             stf_detect,
	output logic             sync_done,
	output logic             phr_valid,
	output logic [29:0]      phr_bits,
	output logic             frame_end,
	output logic             sym_pwr_valid,
	output logic [7:0]       sym_pwr_db
);
	initial
	begin
		{stf_detect, sync_done, phr_valid, frame_end, sym_pwr_valid} = 5'h00;
		phr_bits = 30'h2aaaaaaa;
		sym_pwr_db = 8'h00;
	end
	function automatic logic [7:0] hcs(input logic [21:0] d);
		logic [7:0] c;
		c = 8'hff;
		for (int i = 21; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction
	// A corrupt frame flips one check bit so only the header check can reject it.
	task automatic send(input logic [21:0] h, input logic bad);
		@(posedge sys_clk) stf_detect <= 1'b1;
		@(posedge sys_clk) stf_detect <= 1'b0;
		repeat (3) @(posedge sys_clk);
		sync_done <= 1'b1;
		@(posedge sys_clk) sync_done <= 1'b0;
		repeat (2) @(posedge sys_clk);
		phr_bits <= {hcs(h) ^ {7'h00, bad}, h};
		phr_valid <= 1'b1;
		@(posedge sys_clk) phr_valid <= 1'b0;
		phr_bits <= ~phr_bits;
		repeat (3) @(posedge sys_clk);
	endtask
	task automatic pwr(input logic [7:0] db);
		@(posedge sys_clk) sym_pwr_valid <= 1'b1;
		sym_pwr_db <= db;
		@(posedge sys_clk) sym_pwr_valid <= 1'b0;
		sym_pwr_db <= ~db;
		repeat (2) @(posedge sys_clk);
	endtask
	task automatic fend();
		@(posedge sys_clk) frame_end <= 1'b1;
		@(posedge sys_clk) frame_end <= 1'b0;
		repeat (2) @(posedge sys_clk);
	endtask
endmodule

// ===== test/tb.sv
// Self-checking bench for the MR-OFDM receive control block.
`timescale 1ns/1ps
module tb;
	import mor_pkg::*;
	logic        sys_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [4:0]  wb_adr_i;
	logic [3:0]  wb_sel_i, tx_reserved_bits, rs;
	logic [31:0] wb_dat_i, wb_dat_o, rdata, v;
	logic        stf_detect, sync_done, phr_valid, frame_end, sym_pwr_valid;
	logic [29:0] phr_bits;
	logic [7:0]  sym_pwr_db, avg_power;
	logic        hunt_enable, reduced_span, gain_freeze, gain_hold_pulse;
	logic        frame_start_pulse, resync_pulse, interleaving_depth_select;
	logic        spurious_comp_enable, lf, il, spc;
	logic [2:0]  hdr_rate_code, preamble_detect_threshold, tx_rate_code, rt, pt;
	logic [8:0]  descr_seed;
	logic [1:0]  bandwidth_option, k2;
	logic [10:0] ln;
	logic [21:0] h;
	int          n_errors, total_checks, n_hold, n_fs, n_rs;
	mor_rx_ctrl dut_u (.sys_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .stf_detect, .sync_done,
		.phr_valid, .phr_bits, .frame_end, .sym_pwr_valid, .sym_pwr_db, .avg_power,
		.hunt_enable, .reduced_span, .gain_freeze, .gain_hold_pulse, .frame_start_pulse,
		.resync_pulse, .hdr_rate_code, .descr_seed, .bandwidth_option,
		.interleaving_depth_select, .preamble_detect_threshold, .spurious_comp_enable,
		.tx_rate_code, .tx_reserved_bits);
	mor_tx_model tx_u (.sys_clk, .stf_detect, .sync_done, .phr_valid, .phr_bits,
		.frame_end, .sym_pwr_valid, .sym_pwr_db);
	always #2.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
	begin
		if (gain_hold_pulse === 1'b1) n_hold++;
		if (frame_start_pulse === 1'b1) n_fs++;
		if (resync_pulse === 1'b1) n_rs++;
	end
	task automatic summarize();
		if (n_errors == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Classic single cycle; the request stays put until ack is sampled high.
	task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
		n = 0;
		do
			@(posedge sys_clk) n++;
		while (wb_ack_o !== 1'b1 && n < 50);
		rdata = wb_dat_o;
		{wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
		if (n >= 50)
		begin
			n_errors++;
			summarize();
		end
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] e, input string nm);
		wb(1'b0, a, 32'h00000000);
		chk(nm, e, rdata);
	endtask
	function automatic logic [2:0] hr(input logic [1:0] o);
		return (o == 2'h3) ? 3'h2 : (o == 2'h2) ? 3'h1 : 3'h0;
	endfunction
	function automatic logic [8:0] sd(input logic [1:0] i);
		return (i == 2'h0) ? 9'h017 : (i == 2'h1) ? 9'h177 : (i == 2'h2) ? 9'h01c : 9'h17c;
	endfunction
	initial
	begin
		{sys_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i} = 10'h000;
		{wb_sel_i, wb_dat_i, avg_power} = 44'h0;
		void'($urandom(70304));
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		wb_sel_i <= 4'hf;
		rd(MOR_OFS_CTRL, 32'h004, "ctrl_reset");
		rd(MOR_OFS_TXHDR, 32'h0, "txhdr_reset");
		chk("seed_reset", 32'h017, descr_seed);
		rd(5'h1e, 32'h0, "unmapped");
		repeat (4)
		begin
			v = $urandom;
			wb(1'b1, MOR_OFS_TXHDR, v);
			rd(MOR_OFS_TXHDR, v & 32'hf7, "txhdr");
			chk("tx_rate", v[2:0], tx_rate_code);
			chk("tx_rsv", v[7:4], tx_reserved_bits);
		end
		for (int k = 0; k < 4; k++)
		begin
			k2 = k[1:0];
			{lf, il, pt, rt, rs} = 12'($urandom);
			rt = rt % 3'h7;
			pt = (k2 == 2'h3) ? 3'h3 : (k2 == 2'h2) ? 3'h4 : 3'h5;
			spc = (k2 != 2'h3);
			ln = 11'($urandom_range(2047, 1));
			// Gain target, filters and energy averaging sit outside.
			avg_power <= 8'($urandom);
			wb(1'b1, MOR_OFS_CTRL, {23'h0, pt, k2, il, 1'b1, lf, 1'b1});
			wb(1'b1, MOR_OFS_RXHDR, {28'h0, spc, 3'h0});
			repeat (2) @(posedge sys_clk);
			chk("spc", spc, spurious_comp_enable);
			chk("hdr_rate", hr(k2), hdr_rate_code);
			chk("option", k2, bandwidth_option);
			chk("span", lf, reduced_span);
			chk("fields", {il, pt}, {interleaving_depth_select, preamble_detect_threshold});
			chk("hunt", 1, hunt_enable);
			h = {rs[3], k2, rs[2], rs[1], ln, rs[0], 2'b00, rt};
			tx_u.send(h, 1'b0);
			chk("holds", k + 1, n_hold);
			chk("freeze", 1, gain_freeze);
			chk("frames", k + 1, n_fs);
			rd(MOR_OFS_RXHDR, {rs, spc, rt}, "rxhdr");
			rd(MOR_OFS_SEED, k2, "seed_idx");
			chk("descr_seed", sd(k2), descr_seed);
			rd(MOR_OFS_LEN_HI, ln[10:8], "len_hi");
			rd(MOR_OFS_LEN_LO, ln[7:0], "len_lo");
			rd(MOR_OFS_ENERGY, avg_power, "energy");
			rd(MOR_OFS_EVENT, 32'h103, "events");
			wb(1'b1, MOR_OFS_EVENT, 32'h3);
			rd(MOR_OFS_EVENT, 32'h100, "events_clr");
			tx_u.fend();
			chk("freeze_end", 0, gain_freeze);
		end
		tx_u.send(h, 1'b1);
		h[16:6] = 11'h000;
		tx_u.send(h, 1'b0);
		chk("frames_bad", 4, n_fs);
		rd(MOR_OFS_LEN_LO, ln[7:0], "len_kept");
		h[16:6] = ln;
		tx_u.send(h, 1'b0);
		tx_u.pwr(8'h0a);
		tx_u.pwr(8'h16);
		chk("no_resync", 0, n_rs);
		tx_u.pwr(8'h23);
		chk("resync", 1, n_rs);
		chk("resync_hunt", 32'h2, {hunt_enable, gain_freeze});
		rd(MOR_OFS_EVENT, 32'h007, "events_rs");
		wb(1'b1, MOR_OFS_CTRL, 32'h031);
		tx_u.send(h, 1'b0);
		tx_u.pwr(8'h0a);
		tx_u.pwr(8'h3c);
		chk("override_off", 1, n_rs);
		tx_u.fend();
		wb(1'b1, MOR_OFS_CTRL, 32'h0);
		repeat (2) @(posedge sys_clk);
		chk("disabled", 0, hunt_enable);
		summarize();
	end
endmodule
